// file: rtl/watchdog_pkg.sv
package watchdog_pkg;

	// data path widths
	localparam int CNT_W  = 32;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// register byte offsets
	localparam logic [ADDR_W-1:0] OFF_RELOAD = 8'h00; // reload value
	localparam logic [ADDR_W-1:0] OFF_COUNT  = 8'h04; // live count, read only
	localparam logic [ADDR_W-1:0] OFF_CTRL   = 8'h08; // watchdog control
	localparam logic [ADDR_W-1:0] OFF_INTCLR = 8'h0c; // clear and reload
	localparam logic [ADDR_W-1:0] OFF_STAT   = 8'h10; // sticky events
	localparam logic [ADDR_W-1:0] OFF_MASK   = 8'h14; // event mask
	localparam logic [ADDR_W-1:0] OFF_GUARD  = 8'h18; // write guard

	// control fields
	localparam int CTRL_W       = 3;
	localparam int CTRL_INT_EN  = 0;
	localparam int CTRL_RES_EN  = 1;
	localparam int CTRL_CLK_BUS = 2;

	// status and mask fields
	localparam int STAT_W       = 2;
	localparam int STAT_TIMEOUT = 0;
	localparam int STAT_RESET   = 1;

	// reset values
	localparam logic [CNT_W-1:0]  RELOAD_RST = 32'hffff_ffff;
	localparam logic [CTRL_W-1:0] CTRL_RST   = 3'h0;
	localparam logic [STAT_W-1:0] MASK_RST   = 2'h0;

	// unlock key for the write guard
	localparam logic [DATA_W-1:0] GUARD_KEY = 32'h1acc_e551;

	// one register bus request
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} bus_req_s;

endpackage

// file: rtl/watchdog_tick.sv
`timescale 1ns/1ps
// turns the chosen counting clock into one-cycle enables on mclk
module watchdog_tick (
	// clock and synchronised reset
	input  wire logic mclk,
	input  wire logic rstN,
	// clock choice and sleep clock pin
	input  wire logic useBusClk,
	input  wire logic sleepClk,
	// one pulse per counting clock rising edge
	output logic      tick
);

	logic syncA_reg;  // first synchroniser stage, read only by syncB
	logic syncB_reg;  // second synchroniser stage
	logic syncC_reg;  // delayed copy for edge detection
	logic tick_next;  // next tick value

	////////////////////////////////////////////////////////////////////////
	// bus clock gives an enable each cycle; sleep clock needs its edge
	always_comb begin
		if (useBusClk) begin
			tick_next = 1'b1;
		end else begin
			tick_next = syncB_reg & ~syncC_reg;
		end
	end

	// register stages; the sleep clock is far slower than mclk
	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			syncA_reg <= 1'b0;
			syncB_reg <= 1'b0;
			syncC_reg <= 1'b0;
			tick      <= 1'b0;
		end else begin
			syncA_reg <= sleepClk;
			syncB_reg <= syncA_reg;
			syncC_reg <= syncB_reg;
			tick      <= tick_next;
		end
	end

endmodule

// file: rtl/lockable_system_watchdog.sv
`timescale 1ns/1ps
// Contract
// RULE1: 32-bit counter decrements on each counting edge
// RULE2: start value comes from reload register
// RULE3: reaching zero raises the timeout interrupt
// RULE4: next edge after zero reloads, keeps counting
// RULE5: second zero while pending: reset, freeze
// RULE6: control bits enable interrupt and reset
// RULE7: interrupt disabled holds the counter still
// RULE8: re-enabling restarts from the reload value
// RULE9: software may reload the counter anytime
// RULE10: counting clock is sleep or bus clock
// RULE11: key written to guard unlocks all registers
// RULE12: other guard value blocks all other writes
// RULE13: debug mode halts the watchdog
// RULE14: software disables watchdog before sleep
// RULE15: sleep clock unless bus clock forced
// RULE16: clearing interrupt cancels the pending reset
module lockable_system_watchdog (
	// clock and reset
	input  wire logic                              mclk,
	input  wire logic                              arst_n,
	// register port
	input  wire logic [watchdog_pkg::ADDR_W-1:0]   addr,
	input  wire logic [watchdog_pkg::DATA_W-1:0]   wdata,
	input  wire logic                              wrStb,
	input  wire logic                              rdStb,
	output logic      [watchdog_pkg::DATA_W-1:0]   rdata,
	// pins from outside the mclk domain
	input  wire logic                              sleepClk,
	input  wire logic                              dbgMode,
	// outputs
	output logic                                   timeoutInt,
	output logic                                   sysRst,
	output logic                                   irq
);

	////////////////////////////////////////////////////////////////////////
	// reset release and pin synchronisers

	logic rstMeta_reg;  // first reset stage
	logic rstN;         // released reset used by the design
	logic dbgMeta_reg;  // first debug stage, read only by dbgSync_reg
	logic dbgSync_reg;  // debug level in mclk domain

	// release the reset in step with mclk
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rstMeta_reg <= 1'b0;
			rstN        <= 1'b0;
		end else begin
			rstMeta_reg <= 1'b1;
			rstN        <= rstMeta_reg;
		end
	end

	// debug level passes two flops before use
	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			dbgMeta_reg <= 1'b0;
			dbgSync_reg <= 1'b0;
		end else begin
			dbgMeta_reg <= dbgMode;
			dbgSync_reg <= dbgMeta_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// address decode

	// true when the request hits the given offset
	function automatic logic hit(
		input logic [watchdog_pkg::ADDR_W-1:0] a,
		input logic [watchdog_pkg::ADDR_W-1:0] off
	);
		hit = (a == off);
	endfunction

	watchdog_pkg::bus_req_s req;  // bundled bus request
	assign req = '{addr: addr, wdata: wdata, wr: wrStb, rd: rdStb};

	////////////////////////////////////////////////////////////////////////
	// state

	logic [watchdog_pkg::CNT_W-1:0]  reload_reg,  reload_next;
	logic [watchdog_pkg::CNT_W-1:0]  cnt_reg,     cnt_next;
	logic [watchdog_pkg::CTRL_W-1:0] ctrl_reg,    ctrl_next;
	logic [watchdog_pkg::STAT_W-1:0] stat_reg,    stat_next;
	logic [watchdog_pkg::STAT_W-1:0] mask_reg,    mask_next;
	logic                            locked_reg,  locked_next;
	logic                            pend_reg,    pend_next;
	logic                            sysRst_next;
	logic                            irq_next;
	logic                            tmo_next;
	logic [watchdog_pkg::DATA_W-1:0] rdata_next;

	logic                            tick;       // counting clock enable
	logic                            wrOk;       // write passes the guard
	logic                            running;    // counter may advance
	logic                            swLoad;     // software reload request
	logic                            intEnRise;  // interrupt re-enabled
	logic                            clrWrite;   // interrupt clear write
	logic [watchdog_pkg::CNT_W-1:0]  cntDec;     // count after one edge
	logic                            zeroHit;    // count arrives at zero
	logic                            rstEvent;   // second zero, reset due

	// counting clock choice; default select is the sleep clock
	watchdog_tick u_tick (
		.mclk      (mclk),
		.rstN      (rstN),
		.useBusClk (ctrl_reg[watchdog_pkg::CTRL_CLK_BUS]), // [RULE10] [RULE15]
		.sleepClk  (sleepClk),
		.tick      (tick)
	);

	////////////////////////////////////////////////////////////////////////
	// next state of the counter, guard and registers
	always_comb begin
		// guard holds back all writes but its own
		wrOk = req.wr
			& (~locked_reg | hit(req.addr, watchdog_pkg::OFF_GUARD)); // [RULE12]
		clrWrite  = wrOk & hit(req.addr, watchdog_pkg::OFF_INTCLR);
		intEnRise = wrOk & hit(req.addr, watchdog_pkg::OFF_CTRL)
			& req.wdata[watchdog_pkg::CTRL_INT_EN]
			& ~ctrl_reg[watchdog_pkg::CTRL_INT_EN];
		// reload on value write, clear write or re-enable
		swLoad = (wrOk & hit(req.addr, watchdog_pkg::OFF_RELOAD))
			| clrWrite | intEnRise; // [RULE9] [RULE8]
		// halted when disabled, in debug or after reset fired
		running = ctrl_reg[watchdog_pkg::CTRL_INT_EN] & ~dbgSync_reg
			& ~sysRst; // [RULE7] [RULE13]
		// a zero count reloads on the following edge
		if (cnt_reg == '0) begin
			cntDec = reload_reg; // [RULE4]
		end else begin
			cntDec = cnt_reg - 32'h1; // [RULE1]
		end
		zeroHit  = running & tick & ~swLoad & (cntDec == '0);
		rstEvent = zeroHit & pend_reg
			& ctrl_reg[watchdog_pkg::CTRL_RES_EN]; // [RULE6]

		// register writes
		reload_next = reload_reg;
		ctrl_next   = ctrl_reg;
		mask_next   = mask_reg;
		locked_next = locked_reg;
		if (wrOk && hit(req.addr, watchdog_pkg::OFF_RELOAD)) begin
			reload_next = req.wdata;
		end
		if (wrOk && hit(req.addr, watchdog_pkg::OFF_CTRL)) begin
			ctrl_next = req.wdata[watchdog_pkg::CTRL_W-1:0]; // [RULE6]
		end
		if (wrOk && hit(req.addr, watchdog_pkg::OFF_MASK)) begin
			mask_next = req.wdata[watchdog_pkg::STAT_W-1:0];
		end
		if (req.wr && hit(req.addr, watchdog_pkg::OFF_GUARD)) begin
			locked_next = // [RULE11] [RULE12]
				(req.wdata != watchdog_pkg::GUARD_KEY);
		end

		// counter; frozen for good once the reset has gone out
		cnt_next = cnt_reg;
		if (sysRst) begin
			cnt_next = cnt_reg; // [RULE5]
		end else if (swLoad) begin
			cnt_next = reload_next; // [RULE2] [RULE8] [RULE9]
		end else if (running && tick) begin
			cnt_next = cntDec; // [RULE1] [RULE4]
		end

		// pending interrupt; a clear wins over a new zero
		pend_next = pend_reg;
		if (clrWrite) begin
			pend_next = 1'b0; // [RULE16]
		end
		if (zeroHit) begin
			pend_next = 1'b1; // [RULE3]
		end
		sysRst_next = sysRst | rstEvent; // [RULE5]
		tmo_next    = pend_next
			& ctrl_next[watchdog_pkg::CTRL_INT_EN]; // [RULE3]

		// sticky events: reading clears, a new event still lands
		stat_next = stat_reg;
		if (req.rd && hit(req.addr, watchdog_pkg::OFF_STAT)) begin
			stat_next = '0;
		end
		stat_next[watchdog_pkg::STAT_TIMEOUT] =
			stat_next[watchdog_pkg::STAT_TIMEOUT] | (zeroHit & ~pend_reg);
		stat_next[watchdog_pkg::STAT_RESET] =
			stat_next[watchdog_pkg::STAT_RESET] | rstEvent;
		irq_next = |(stat_next & mask_next);

		// read data, unmapped offsets answer zero
		rdata_next = '0;
		if (req.rd) begin
			case (req.addr)
				watchdog_pkg::OFF_RELOAD: rdata_next = reload_reg;
				watchdog_pkg::OFF_COUNT:  rdata_next = cnt_reg;
				watchdog_pkg::OFF_CTRL: begin
					rdata_next[watchdog_pkg::CTRL_W-1:0] = ctrl_reg;
				end
				watchdog_pkg::OFF_STAT: begin
					rdata_next[watchdog_pkg::STAT_W-1:0] = stat_reg;
				end
				watchdog_pkg::OFF_MASK: begin
					rdata_next[watchdog_pkg::STAT_W-1:0] = mask_reg;
				end
				watchdog_pkg::OFF_GUARD:  rdata_next[0] = locked_reg;
				default:                  rdata_next = '0;
			endcase
		end
	end

	// state registers; the guard starts open
	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			reload_reg <= watchdog_pkg::RELOAD_RST;
			cnt_reg    <= watchdog_pkg::RELOAD_RST;
			ctrl_reg   <= watchdog_pkg::CTRL_RST;
			stat_reg   <= '0;
			mask_reg   <= watchdog_pkg::MASK_RST;
			locked_reg <= 1'b0;
			pend_reg   <= 1'b0;
			sysRst     <= 1'b0;
			timeoutInt <= 1'b0;
			irq        <= 1'b0;
			rdata      <= '0;
		end else begin
			reload_reg <= reload_next;
			cnt_reg    <= cnt_next;
			ctrl_reg   <= ctrl_next;
			stat_reg   <= stat_next;
			mask_reg   <= mask_next;
			locked_reg <= locked_next;
			pend_reg   <= pend_next;
			sysRst     <= sysRst_next;
			timeoutInt <= tmo_next;
			irq        <= irq_next;
			rdata      <= rdata_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks

	sequence s_resetHeld;
		sysRst ##1 sysRst;
	endsequence

	sequence s_edgeAdvance;
		tick && running && !swLoad && !sysRst;
	endsequence

	property p_decrement;
		@(posedge mclk) disable iff (!rstN)
		s_edgeAdvance and (cnt_reg != '0) |=> cnt_reg == $past(cnt_reg) - 32'h1;
	endproperty
	a_decrement: assert property (p_decrement) // [RULE1]
		else $error("count not decremented");

	property p_reloadAfterZero;
		@(posedge mclk) disable iff (!rstN)
		s_edgeAdvance and (cnt_reg == '0) |=> cnt_reg == $past(reload_reg);
	endproperty
	a_reloadAfterZero: assert property (p_reloadAfterZero) // [RULE4] [RULE2]
		else $error("no reload after zero");

	// the interrupt pin follows the pending flag in the same cycle; looking
	// one cycle later would trip on a clear that software issues at once
	property p_intRaise;
		@(posedge mclk) disable iff (!rstN)
		zeroHit && !pend_reg |=> pend_reg
			&& (timeoutInt || !ctrl_reg[watchdog_pkg::CTRL_INT_EN]);
	endproperty
	a_intRaise: assert property (p_intRaise) // [RULE3]
		else $error("zero did not raise interrupt");

	property p_resetFire;
		@(posedge mclk) disable iff (!rstN)
		zeroHit && pend_reg && ctrl_reg[watchdog_pkg::CTRL_RES_EN]
			|=> s_resetHeld;
	endproperty
	a_resetFire: assert property (p_resetFire) // [RULE5]
		else $error("second zero gave no reset");

	property p_frozen;
		@(posedge mclk) disable iff (!rstN)
		sysRst |=> $stable(cnt_reg) && sysRst;
	endproperty
	a_frozen: assert property (p_frozen) // [RULE5]
		else $error("counter moved after reset");

	property p_holdDisabled;
		@(posedge mclk) disable iff (!rstN)
		(!ctrl_reg[watchdog_pkg::CTRL_INT_EN] || dbgSync_reg) && !swLoad
			|=> $stable(cnt_reg);
	endproperty
	a_holdDisabled: assert property (p_holdDisabled) // [RULE7] [RULE13]
		else $error("counter moved while halted");

	property p_reenable;
		@(posedge mclk) disable iff (!rstN)
		intEnRise && !sysRst |=> cnt_reg == $past(reload_reg)
			&& ctrl_reg[watchdog_pkg::CTRL_INT_EN];
	endproperty
	a_reenable: assert property (p_reenable) // [RULE8]
		else $error("re-enable did not reload");

	property p_lockBlocks;
		@(posedge mclk) disable iff (!rstN)
		req.wr && locked_reg && !hit(req.addr, watchdog_pkg::OFF_GUARD)
			|=> $stable(reload_reg) && $stable(ctrl_reg) && $stable(mask_reg);
	endproperty
	a_lockBlocks: assert property (p_lockBlocks) // [RULE12]
		else $error("locked register changed");

	property p_unlock;
		@(posedge mclk) disable iff (!rstN)
		req.wr && hit(req.addr, watchdog_pkg::OFF_GUARD)
			|=> locked_reg == ($past(req.wdata) != watchdog_pkg::GUARD_KEY);
	endproperty
	a_unlock: assert property (p_unlock) // [RULE11]
		else $error("guard state wrong after write");

	property p_clearCancels;
		@(posedge mclk) disable iff (!rstN)
		clrWrite && !sysRst |=> !pend_reg ##1 !sysRst;
	endproperty
	a_clearCancels: assert property (p_clearCancels) // [RULE16]
		else $error("clear left reset pending");

endmodule

// file: testbench/tb.sv
`timescale 1ns/1ps
module tb;
	////////////////////////////////////////////////////////////////////////
	// bench signals, stimulus driven from time zero
	logic                              mclk        = 1'b0;
	logic                              arst_n      = 1'b0;
	logic [watchdog_pkg::ADDR_W-1:0]   addr        = 8'h00;
	logic [watchdog_pkg::DATA_W-1:0]   wdata       = 32'h0;
	logic                              wrStb       = 1'b0;
	logic                              rdStb       = 1'b0;
	logic                              sleepClk    = 1'b0;
	logic                              dbgMode     = 1'b0;
	logic [watchdog_pkg::DATA_W-1:0]   rdata;
	logic                              timeoutInt;
	logic                              sysRst;
	logic                              irq;
	logic [31:0]                       rv;          // first sample
	logic [31:0]                       rv2;         // second sample
	int                                errors      = 0;
	int                                checks_done = 0;

	// 100 MHz bus clock
	always #5 mclk = ~mclk;

	lockable_system_watchdog dut (
		.mclk       (mclk),
		.arst_n     (arst_n),
		.addr       (addr),
		.wdata      (wdata),
		.wrStb      (wrStb),
		.rdStb      (rdStb),
		.rdata      (rdata),
		.sleepClk   (sleepClk),
		.dbgMode    (dbgMode),
		.timeoutInt (timeoutInt),
		.sysRst     (sysRst),
		.irq        (irq)
	);

	////////////////////////////////////////////////////////////////////////
	// compare and count
	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	// one-cycle write strobe, launched right after an edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		addr  <= a;
		wdata <= d;
		wrStb <= 1'b1;
		@(posedge mclk);
		wrStb <= 1'b0;
	endtask

	// data stand only in the cycle after the strobe, so sample mid-cycle
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge mclk);
		addr  <= a;
		rdStb <= 1'b1;
		@(posedge mclk);
		rdStb <= 1'b0;
		@(negedge mclk);
		d = rdata;
	endtask

	// slow sleep clock pulses, well under a quarter of mclk
	task automatic edges(input int n);
		repeat (n) begin
			@(posedge mclk);
			sleepClk <= 1'b1;
			repeat (6) @(posedge mclk);
			sleepClk <= 1'b0;
			repeat (6) @(posedge mclk);
		end
		repeat (6) @(posedge mclk);
	endtask

	// bounded wait for timeoutInt (sel 0) or sysRst (sel 1)
	task automatic waitSig(input int sel, input int lim);
		int n;
		n = 0;
		while ((sel == 0 ? timeoutInt : sysRst) !== 1'b1 && n < lim) begin
			@(negedge mclk);
			n++;
		end
		if (n >= lim) begin
			errors++;
			$display("Error wait %0d expected 1 seen timeout", sel);
			conclude();
		end
	endtask

	task automatic conclude;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		repeat (5) @(posedge mclk);
		arst_n <= 1'b1;
		repeat (3) @(posedge mclk);
		// reset values and an unmapped read
		rd(watchdog_pkg::OFF_RELOAD, rv);
		chk("reload", 32'hffff_ffff, rv);
		rd(watchdog_pkg::OFF_COUNT, rv);
		chk("count", 32'hffff_ffff, rv);
		rd(watchdog_pkg::OFF_CTRL, rv);
		chk("ctrl", 32'h0, rv);
		rd(watchdog_pkg::OFF_MASK, rv);
		chk("mask", 32'h0, rv);
		rd(8'h40, rv);
		chk("unmapped", 32'h0, rv);
		$display("test reset values done");

		// locked guard refuses other writes, key reopens them
		wr(watchdog_pkg::OFF_GUARD, 32'h0);
		wr(watchdog_pkg::OFF_RELOAD, 32'h5);
		rd(watchdog_pkg::OFF_RELOAD, rv);
		chk("locked reload", 32'hffff_ffff, rv);
		rd(watchdog_pkg::OFF_GUARD, rv);
		chk("guard locked", 32'h1, rv);
		wr(watchdog_pkg::OFF_GUARD, watchdog_pkg::GUARD_KEY);
		wr(watchdog_pkg::OFF_RELOAD, 32'h5);
		rd(watchdog_pkg::OFF_RELOAD, rv);
		chk("open reload", 32'h5, rv);
		$display("test write guard done");

		// sleep clock counting, hold, restart and software reload
		wr(watchdog_pkg::OFF_RELOAD, 32'ha);
		wr(watchdog_pkg::OFF_CTRL, 32'h1);
		rd(watchdog_pkg::OFF_COUNT, rv);
		chk("start", 32'ha, rv);
		edges(3);
		rd(watchdog_pkg::OFF_COUNT, rv);
		chk("sleep count", 32'h7, rv);
		// software stops the watchdog before the sleep clock stretch
		wr(watchdog_pkg::OFF_CTRL, 32'h0);
		edges(2);
		rd(watchdog_pkg::OFF_COUNT, rv);
		chk("held", 32'h7, rv);
		wr(watchdog_pkg::OFF_CTRL, 32'h1);
		rd(watchdog_pkg::OFF_COUNT, rv);
		chk("restart", 32'ha, rv);
		edges(2);
		wr(watchdog_pkg::OFF_INTCLR, 32'h0);
		rd(watchdog_pkg::OFF_COUNT, rv);
		chk("sw reload", 32'ha, rv);
		$display("test counting done");

		// first timeout on bus clock, reset generation off
		wr(watchdog_pkg::OFF_MASK, 32'h1);
		wr(watchdog_pkg::OFF_RELOAD, 32'h14);
		wr(watchdog_pkg::OFF_CTRL, 32'h5);
		waitSig(0, 40);
		chk("irq", 32'h1, {31'h0, irq});
		// the tick after the zero count restores the reload value
		rd(watchdog_pkg::OFF_COUNT, rv);
		chk("reloaded", 32'h14, rv);
		rd(watchdog_pkg::OFF_STAT, rv);
		chk("status", 32'h1, rv);
		@(negedge mclk);
		chk("irq cleared", 32'h0, {31'h0, irq});
		repeat (25) @(negedge mclk);
		chk("no reset", 32'h0, {31'h0, sysRst});
		chk("int held", 32'h1, {31'h0, timeoutInt});
		wr(watchdog_pkg::OFF_INTCLR, 32'h0);
		repeat (2) @(negedge mclk);
		chk("int clear", 32'h0, {31'h0, timeoutInt});
		$display("test timeout done");

		// debug mode halts the count
		wr(watchdog_pkg::OFF_RELOAD, 32'h3e8);
		@(posedge mclk);
		dbgMode <= 1'b1;
		repeat (5) @(posedge mclk);
		rd(watchdog_pkg::OFF_COUNT, rv);
		repeat (4) @(posedge mclk);
		rd(watchdog_pkg::OFF_COUNT, rv2);
		chk("debug hold", rv, rv2);
		@(posedge mclk);
		dbgMode <= 1'b0;
		$display("test debug done");

		// second zero without a clear fires reset and freezes count
		wr(watchdog_pkg::OFF_RELOAD, 32'h14);
		wr(watchdog_pkg::OFF_CTRL, 32'h7);
		waitSig(0, 40);
		waitSig(1, 40);
		rd(watchdog_pkg::OFF_STAT, rv);
		chk("status rst", 32'h3, rv);
		rd(watchdog_pkg::OFF_COUNT, rv);
		repeat (4) @(posedge mclk);
		rd(watchdog_pkg::OFF_COUNT, rv2);
		chk("frozen", rv, rv2);
		@(posedge mclk);
		arst_n <= 1'b0;
		repeat (2) @(negedge mclk);
		chk("rst cleared", 32'h0, {31'h0, sysRst});
		@(posedge mclk);
		arst_n <= 1'b1;
		repeat (3) @(posedge mclk);
		rd(watchdog_pkg::OFF_CTRL, rv);
		chk("ctrl again", 32'h0, rv);
		$display("test system reset done");
		conclude();
	end

	// overall limit on the run
	initial begin
		#500000;
		errors++;
		$display("Error run expected end seen timeout");
		conclude();
	end
endmodule
